// *** logic/tpw_timer8_pwm.sv ***
// Fast and phase-correct PWM waveform generator of an 8-bit timer
`timescale 1ns/100ps
module tpw_timer8_pwm (
    input wire logic clk,
    input wire logic reset_n,
    input wire tpw_pkg::tpw_cfg_t cfg,
    input wire logic [7:0] compareValueA,
    input wire logic [7:0] compareValueB,
    input wire tpw_pkg::tpw_port_t portCtl,
    input wire logic overflowClear,
    output logic [7:0] countValue,
    output logic overflowFlag,
    output logic waveOutA,
    output logic waveOutB,
    output tpw_pkg::tpw_pin_t pins
);
    import tpw_pkg::*;

    logic [2:0] waveMode;
    tpw_slope_t slope;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] prescMask;
    logic prescOn;
    logic tick;
    logic countUp;
    logic [7:0] topVal;
    logic atTop;
    logic atBottom;
    logic loadBuf;
    logic setOverflow;
    logic [7:0] bufCmp [0:1];
    logic waveState [0:1];
    logic [1:0] chAct [0:1];

    // Full mode from the split field
    assign waveMode = {cfg.waveModeUpperBit, cfg.waveModeSel};

    // Decode counting scheme; other modes are handled elsewhere and hold here
    always_comb
    begin
        case (waveMode)
            MODE_FAST_FIX, MODE_FAST_VAR: slope = SLOPE_FAST;
            MODE_PHASE_FIX, MODE_PHASE_VAR: slope = SLOPE_PHASE;
            default: slope = SLOPE_NONE;
        endcase
    end

    // Prescaler tick mask; unused select codes stop the timer
    always_comb
    begin
        prescOn = 1'b1;
        case (cfg.clockSelect)
            CS_DIV1: prescMask = MASK_DIV1;
            CS_DIV8: prescMask = MASK_DIV8;
            CS_DIV64: prescMask = MASK_DIV64;
            CS_DIV256: prescMask = MASK_DIV256;
            CS_DIV1024: prescMask = MASK_DIV1024;
            default:
            begin
                prescMask = MASK_DIV1;
                prescOn = 1'b0;
            end
        endcase
    end

    // Free-running divider; power-of-two masks share one counter
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            presc <= PRESC_RESET;
        else
            presc <= presc + 10'h001;
    end

    // Timer tick, registered so all timer logic sees a clean enable
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            tick <= 1'b0;
        else
            tick <= prescOn && ((presc & prescMask) == prescMask);
    end

    // TOP is fixed or the buffered compare A
    assign topVal = cfg.waveModeUpperBit ? bufCmp[0] : TOP_FIXED;
    assign atTop = (countValue == topVal);
    assign atBottom = (countValue == BOTTOM);

    // Compare buffers load at bottom (fast) or TOP (phase), else directly
    assign loadBuf = (slope == SLOPE_NONE)
        || (tick && (slope == SLOPE_FAST) && atTop)
        || (tick && (slope == SLOPE_PHASE) && countUp && atTop);

    // Counter and direction; everything moves on timer ticks only
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            countValue <= COUNT_RESET;
            countUp <= 1'b1;
        end
        else if (tick)
        begin
            case (slope)
                SLOPE_FAST:
                begin
                    countUp <= 1'b1;
                    if (atTop)
                        countValue <= BOTTOM;
                    else
                        countValue <= countValue + 8'h01;
                end
                SLOPE_PHASE:
                begin
                    if (countUp)
                    begin
                        if (atTop)
                        begin
                            // TOP already shown for this tick; next one steps down
                            countUp <= 1'b0;
                            countValue <= (topVal == BOTTOM) ? BOTTOM : topVal - 8'h01;
                        end
                        else
                            countValue <= countValue + 8'h01;
                    end
                    else
                    begin
                        if (atBottom)
                        begin
                            countUp <= 1'b1;
                            countValue <= (topVal == BOTTOM) ? BOTTOM : 8'h01;
                        end
                        else
                            countValue <= countValue - 8'h01;
                    end
                end
                default:
                begin
                    countValue <= countValue;
                end
            endcase
        end
    end

    // Overflow at TOP (fast) or bottom (phase); a set beats a clear
    assign setOverflow = tick && (((slope == SLOPE_FAST) && atTop)
        || ((slope == SLOPE_PHASE) && !countUp && atBottom));

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            overflowFlag <= 1'b0;
        else if (setOverflow)
            overflowFlag <= 1'b1;
        else if (overflowClear)
            overflowFlag <= 1'b0;
    end

    assign chAct[0] = cfg.outActionA;
    assign chAct[1] = cfg.outActionB;

    // One compare unit per channel; only channel A may toggle
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        logic [7:0] cmpIn;
        logic hit;
        logic pwmAct;
        logic invert;
        logic toggle;
        logic upLevel;
        logic downLevel;

        assign cmpIn = (ch == 0) ? compareValueA : compareValueB;
        assign hit = (countValue == bufCmp[ch]);
        assign pwmAct = chAct[ch][1];
        assign invert = (chAct[ch] == ACT_INV);
        assign toggle = (ch == 0) && cfg.waveModeUpperBit && (chAct[ch] == ACT_TOGGLE);
        assign upLevel = invert;
        assign downLevel = !invert;

        // Double buffer so a mid-period write cannot glitch the waveform
        always_ff @(posedge clk)
        begin
            if (!reset_n)
                bufCmp[ch] <= COMPARE_RESET;
            else if (loadBuf)
                bufCmp[ch] <= cmpIn;
        end

        // Waveform state; action bits act at once, not buffered
        always_ff @(posedge clk)
        begin
            if (!reset_n)
                waveState[ch] <= WAVE_RESET;
            else if (tick)
            begin
                case (slope)
                    SLOPE_FAST:
                    begin
                        if (toggle)
                        begin
                            if (hit)
                                waveState[ch] <= !waveState[ch];
                        end
                        else if (pwmAct)
                        begin
                            // Bottom action wins at TOP: spike at 0, flat at MAX
                            if (atTop)
                                waveState[ch] <= !invert;
                            else if (hit)
                                waveState[ch] <= invert;
                        end
                    end
                    SLOPE_PHASE:
                    begin
                        if (toggle)
                        begin
                            if (hit)
                                waveState[ch] <= !waveState[ch];
                        end
                        else if (pwmAct)
                        begin
                            if (countUp && atTop)
                                // Forced level also repairs a missed up-match
                                waveState[ch] <= (bufCmp[ch] >= topVal) ? downLevel
                                    : upLevel;
                            else if (!countUp && atBottom)
                                waveState[ch] <= (bufCmp[ch] == BOTTOM) ? upLevel
                                    : downLevel;
                            else if (hit)
                                waveState[ch] <= countUp ? upLevel : downLevel;
                        end
                    end
                    default:
                    begin
                        waveState[ch] <= waveState[ch];
                    end
                endcase
            end
        end
    end

    assign waveOutA = waveState[0];
    assign waveOutB = waveState[1];

    // Pin drive; registered so pads see flop outputs only
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            pins <= '0;
        else
        begin
            pins.oeA <= portCtl.dirA;
            pins.oeB <= portCtl.dirB;
            pins.outA <= (cfg.outActionA != ACT_OFF) ? waveState[0] : portCtl.dataA;
            pins.outB <= (cfg.outActionB != ACT_OFF) ? waveState[1] : portCtl.dataB;
        end
    end

    // Checks on counting, flags and pin routing
    property p_fast_wrap;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && atTop |=> countValue == BOTTOM;
    endproperty
    a_fast_wrap: assert property (p_fast_wrap) else $error("fast count did not wrap");

    property p_fast_inc;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && !atTop |=> countValue == $past(countValue) + 8'h01;
    endproperty
    a_fast_inc: assert property (p_fast_inc) else $error("fast count did not step");

    property p_fast_ovf;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && atTop |=> overflowFlag;
    endproperty
    a_fast_ovf: assert property (p_fast_ovf) else $error("no overflow at TOP");

    property p_phase_top;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && countUp && atTop && (topVal > 8'h01)
        |=> !countUp && (countValue == $past(topVal) - 8'h01);
    endproperty
    a_phase_top: assert property (p_phase_top) else $error("no reversal at TOP");

    property p_phase_ovf;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && !countUp && atBottom |=> overflowFlag && countUp;
    endproperty
    a_phase_ovf: assert property (p_phase_ovf) else $error("no overflow at bottom");

    property p_fast_set;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && atTop && (cfg.outActionA == ACT_NONINV) |=> waveOutA;
    endproperty
    a_fast_set: assert property (p_fast_set) else $error("output not set at bottom");

    property p_phase_up_clr;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && countUp && !atTop && (countValue == bufCmp[0])
        && (cfg.outActionA == ACT_NONINV) |=> !waveOutA;
    endproperty
    a_phase_up_clr: assert property (p_phase_up_clr) else $error("up-match did not clear");

    property p_pin_oe;
        @(posedge clk) disable iff (!reset_n)
        reset_n |=> pins.oeA == $past(portCtl.dirA);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable not from direction");

    property p_disconnect;
        @(posedge clk) disable iff (!reset_n)
        reset_n && (cfg.outActionB == ACT_OFF) |=> pins.outB == $past(portCtl.dataB);
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("port not restored");

    property p_hold;
        @(posedge clk) disable iff (!reset_n)
        !tick |=> $stable(countValue) && $stable(waveOutA);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved without tick");

    property p_div8;
        @(posedge clk) disable iff (!reset_n)
        tick && (cfg.clockSelect == CS_DIV8) && ($past(cfg.clockSelect) == CS_DIV8)
        |=> !tick [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide-by-8 tick too fast");

    // Match below TOP must clear a non-inverted fast waveform
    property p_fast_clr;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && !atTop && (countValue == bufCmp[0])
        && (cfg.outActionA == ACT_NONINV) |=> !waveOutA;
    endproperty
    a_fast_clr: assert property (p_fast_clr) else $error("fast match did not clear");

    // Dual-slope turns upward right after bottom
    property p_phase_turn;
        @(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && !countUp && atBottom && (topVal != BOTTOM)
        |=> countValue == 8'h01;
    endproperty
    a_phase_turn: assert property (p_phase_turn) else $error("no turn at bottom");

    // Channel B has no toggle action, so action one leaves it alone
    property p_b_no_toggle;
        @(posedge clk) disable iff (!reset_n)
        tick && (cfg.outActionB == ACT_TOGGLE) |=> $stable(waveOutB);
    endproperty
    a_b_no_toggle: assert property (p_b_no_toggle) else $error("channel B toggled");

    c_fast_wrap: cover property (@(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_FAST) && atTop);
    c_phase_rev: cover property (@(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && countUp && atTop);
    c_toggle: cover property (@(posedge clk) disable iff (!reset_n)
        tick && cfg.waveModeUpperBit && (cfg.outActionA == ACT_TOGGLE)
        && (countValue == bufCmp[0]));
    c_phase_bottom: cover property (@(posedge clk) disable iff (!reset_n)
        tick && (slope == SLOPE_PHASE) && !countUp && atBottom);

endmodule : tpw_timer8_pwm

// *** inc/tpw_pkg.sv ***
// Constants, types and carriers for the 8-bit timer PWM waveform block
//
// Notes on behaviour
// - Mode 3 or 7 counts single-slope from bottom to TOP, then restarts.
// - Single-slope TOP is 0xFF in mode 3, compare A in mode 7.
// - Single-slope non-inverting clears on match, sets at bottom; inverting reversed.
// - Single-slope counter increments to TOP, clears on next timer tick.
// - Single-slope sets the overflow flag each time the counter reaches TOP.
// - Action two gives non-inverted, action three inverted waveform in PWM modes.
// - With upper mode bit, action one toggles output A on match; B never.
// - Waveform reaches the pin only while its direction bit selects output.
// - Fixed-TOP single-slope period is 256 ticks; prescale 1, 8, 64, 256, 1024.
// - Single-slope compare A at bottom spikes once per period; at MAX constant.
// - Single-slope toggle gives 50% duty; compare values stay double-buffered.
// - Mode 1 or 5 counts dual-slope, up to TOP then down to bottom.
// - Dual-slope TOP is 0xFF in mode 1, compare A in mode 5.
// - Dual-slope non-inverting clears on up-match, sets on down-match; inverting reversed.
// - Dual-slope counter holds TOP for exactly one tick, then decrements.
// - Dual-slope sets the overflow flag each time the counter reaches bottom.
// - Fixed-TOP dual-slope period is 510 timer ticks.
// - Dual-slope non-inverted: compare bottom holds low, MAX holds high.
// - Dual-slope output takes the down-match level at bottom, the up-match level if compare is bottom.
// - Dual-slope missed up-match still gets its transition without a match.
// - Compare equal TOP with PWM action: match ignored, set/clear at bottom/TOP.
// - Mode field is three bits: two low bits plus a separate upper bit.
// - Action zero disconnects the waveform and leaves normal port control.
package tpw_pkg;

    // Waveform mode encodings (upper bit concatenated with the two low bits)
    localparam logic [2:0] MODE_FAST_FIX = 3'h3;
    localparam logic [2:0] MODE_FAST_VAR = 3'h7;
    localparam logic [2:0] MODE_PHASE_FIX = 3'h1;
    localparam logic [2:0] MODE_PHASE_VAR = 3'h5;

    // Counter landmarks and reset values
    localparam logic [7:0] TOP_FIXED = 8'hff;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic WAVE_RESET = 1'b0;

    // Output action encodings
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;

    // Prescaler: clock select codes and tick masks for 1, 8, 64, 256, 1024
    localparam int PRESC_W = 10;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03f;
    localparam logic [9:0] MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
    localparam logic [9:0] PRESC_RESET = 10'h000;

    // Counting scheme selected by the mode field
    typedef enum logic [1:0] {SLOPE_NONE, SLOPE_FAST, SLOPE_PHASE} tpw_slope_t;

    // Software-written configuration bits
    typedef struct packed {
        logic waveModeUpperBit;
        logic [1:0] waveModeSel;
        logic [1:0] outActionA;
        logic [1:0] outActionB;
        logic [2:0] clockSelect;
    } tpw_cfg_t;

    // Normal port control for the two waveform pins
    typedef struct packed {
        logic dirA;
        logic dirB;
        logic dataA;
        logic dataB;
    } tpw_port_t;

    // Pin drive toward the pads
    typedef struct packed {
        logic outA;
        logic oeA;
        logic outB;
        logic oeB;
    } tpw_pin_t;

endpackage : tpw_pkg

// *** testbench/testbench.sv ***
// Self-checking bench for the 8-bit timer PWM waveform block
`timescale 1ns/100ps
module testbench;
    import tpw_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    tpw_cfg_t cfg = '0;
    logic [7:0] compareValueA = 8'h00;
    logic [7:0] compareValueB = 8'h00;
    tpw_port_t portCtl = '0;
    logic overflowClear = 1'b0;
    logic [7:0] countValue;
    logic overflowFlag;
    logic waveOutA;
    logic waveOutB;
    tpw_pin_t pins;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 32'h9670;
    logic chk = 1'b0;
    // Reference state
    logic [7:0] mCnt, mBufA, mBufB, mTop;
    logic mUp, mFlag, mWaveA, mWaveB, mTick, mSet;
    tpw_pin_t mPins;
    logic [2:0] mode;
    logic mFast, mPhase;

    assign mode = {cfg.waveModeUpperBit, cfg.waveModeSel};
    assign mFast = (mode == MODE_FAST_FIX) || (mode == MODE_FAST_VAR);
    assign mPhase = (mode == MODE_PHASE_FIX) || (mode == MODE_PHASE_VAR);

    tpw_timer8_pwm tpw_timer8_pwm_i (
        .clk(clk), .reset_n(reset_n), .cfg(cfg),
        .compareValueA(compareValueA), .compareValueB(compareValueB),
        .portCtl(portCtl), .overflowClear(overflowClear),
        .countValue(countValue), .overflowFlag(overflowFlag),
        .waveOutA(waveOutA), .waveOutB(waveOutB), .pins(pins)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // Next waveform state for one channel on a tick
    function automatic logic nextWave(input logic cur, input logic [1:0] act,
        input logic tog, input logic [7:0] cmp);
        logic upLvl;
        upLvl = act[0];
        nextWave = cur;
        if (act == ACT_TOGGLE)
        begin
            if (tog && mCnt == cmp) nextWave = ~cur;
        end
        else if (act[1])
        begin
            if (mFast)
            begin
                if (mCnt == mTop) nextWave = ~upLvl;
                else if (mCnt == cmp) nextWave = upLvl;
            end
            else if (mUp && mCnt == mTop) nextWave = (cmp >= mTop) ? ~upLvl : upLvl;
            else if (!mUp && mCnt == BOTTOM) nextWave = (cmp == BOTTOM) ? upLvl : ~upLvl;
            else if (mCnt == cmp) nextWave = mUp ? upLvl : ~upLvl;
        end
    endfunction : nextWave

    // Reference model, stepped on the same edges as the design
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            mCnt <= COUNT_RESET;
            mUp <= 1'b1;
            mFlag <= 1'b0;
            mWaveA <= WAVE_RESET;
            mWaveB <= WAVE_RESET;
            mBufA <= COMPARE_RESET;
            mBufB <= COMPARE_RESET;
            mTick <= 1'b0;
            mPins <= '0;
        end
        else
        begin
            mTick <= (cfg.clockSelect == CS_DIV1);
            mSet = 1'b0;
            mTop = mode[2] ? mBufA : TOP_FIXED;
            if (!mFast && !mPhase)
            begin
                mBufA <= compareValueA;
                mBufB <= compareValueB;
            end
            else if (mTick)
            begin
                mWaveA <= nextWave(mWaveA, cfg.outActionA, cfg.waveModeUpperBit, mBufA);
                mWaveB <= nextWave(mWaveB, cfg.outActionB, 1'b0, mBufB);
                if (mCnt == mTop && (mFast || mUp))
                begin
                    mBufA <= compareValueA;
                    mBufB <= compareValueB;
                end
                if (mFast)
                begin
                    mSet = (mCnt == mTop);
                    mCnt <= mSet ? BOTTOM : mCnt + 8'h01;
                end
                else if (mUp)
                begin
                    mCnt <= (mCnt == mTop) ? mTop - 8'h01 : mCnt + 8'h01;
                    mUp <= (mCnt != mTop);
                end
                else
                begin
                    mSet = (mCnt == BOTTOM);
                    mCnt <= mSet ? 8'h01 : mCnt - 8'h01;
                    mUp <= mSet;
                end
            end
            mFlag <= mSet | (mFlag & ~overflowClear);
            mPins.outA <= (cfg.outActionA != ACT_OFF) ? mWaveA : portCtl.dataA;
            mPins.oeA <= portCtl.dirA;
            mPins.outB <= (cfg.outActionB != ACT_OFF) ? mWaveB : portCtl.dataB;
            mPins.oeB <= portCtl.dirB;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // Lockstep comparison, away from the launching edge
    always @(negedge clk)
    begin
        if (chk)
        begin
            check("countValue", 16'(countValue), 16'(mCnt));
            check("overflowFlag", 16'(overflowFlag), 16'(mFlag));
            check("waveOutA", 16'(waveOutA), 16'(mWaveA));
            check("waveOutB", 16'(waveOutB), 16'(mWaveB));
            check("pins", 16'(pins), 16'(mPins));
        end
    end

    task automatic do_reset(input int n);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        reset_n <= 1'b1;
    endtask : do_reset

    // Variable-TOP modes need a compare A well above bottom
    task automatic set_cmp(input logic varTop, input logic [7:0] a, input logic [7:0] b);
        compareValueA <= (varTop && a < 8'h02) ? 8'h80 : a;
        compareValueB <= b;
    endtask : set_cmp

    // Main sequence: mode table, corner compares, then prescaler spacing
    initial
    begin
        logic [31:0] rnd;
        logic [7:0] last;
        int k;
        static int divs [6] = '{0, 1, 8, 64, 256, 1024};
        static logic [2:0] modes [4] = '{MODE_FAST_FIX, MODE_FAST_VAR, MODE_PHASE_FIX,
            MODE_PHASE_VAR};
        cfg.clockSelect = CS_DIV1;
        do_reset(10);
        chk = 1'b1;
        for (int s = 0; s < 16; s++)
        begin
            rnd = $random(seed);
            cfg.waveModeUpperBit <= 1'b0;
            cfg.waveModeSel <= 2'h0;
            cfg.outActionA <= (s < 8) ? {1'b1, s[0]} : (s < 12) ? rnd[1:0] : ACT_TOGGLE;
            cfg.outActionB <= (s < 8) ? {1'b1, s[1]} : rnd[3:2];
            if (s < 4) set_cmp(s[0], 8'h00, 8'hff);
            else if (s < 8) set_cmp(s[0], 8'hff, 8'h00);
            else set_cmp(s[0], rnd[15:8], rnd[23:16]);
            do_reset(4);
            repeat (3) @(posedge clk);
            {cfg.waveModeUpperBit, cfg.waveModeSel} <= modes[s % 4];
            for (int i = 0; i < 1200; i++)
            begin
                @(posedge clk);
                rnd = $random(seed);
                portCtl <= rnd[3:0];
                overflowClear <= (rnd[7:4] == 4'h0);
                // Leaving MAX or bottom mid-run exercises the buffer and symmetry fix
                if (i == 600) set_cmp(s[0], rnd[15:8], rnd[23:16]);
                // Fast to dual-slope with the counter possibly past the compare
                if (i == 900 && s % 4 < 2) cfg.waveModeSel <= 2'h1;
            end
        end
        chk = 1'b0;
        {cfg.waveModeUpperBit, cfg.waveModeSel} <= MODE_FAST_FIX;
        for (int c = 1; c <= 5; c++)
        begin
            @(posedge clk);
            cfg.clockSelect <= c[2:0];
            do_reset(2);
            @(negedge clk);
            for (int j = 0; j < 2; j++)
            begin
                last = countValue;
                k = 0;
                while (countValue === last && k < 3000)
                begin
                    @(negedge clk);
                    k++;
                end
            end
            if (k >= 3000)
            begin
                fail_count++;
            end
            check("tick spacing", 16'(k), 16'(divs[c]));
        end
        @(posedge clk);
        cfg.clockSelect <= 3'h0;
        repeat (3) @(negedge clk);
        last = countValue;
        repeat (50) @(negedge clk);
        check("stopped count", 16'(countValue), 16'(last));
        end_of_test();
    end
endmodule : testbench
